// >>> rtl/acr_pkg.sv
// Shared constants, types and field layout of the converter configuration bank
package acr_pkg;

   // Register addresses as seen on the serial port
   localparam logic [6:0] ADDR_THERMAL = 7'h2b;
   localparam logic [6:0] ADDR_SOFT_RESET = 7'h2c;
   localparam logic [6:0] ADDR_BURST = 7'h34;
   localparam logic [6:0] ADDR_SLEEP = 7'h37;
   localparam logic [6:0] ADDR_BIAS = 7'h38;

   // Serial frame layout: read flag, 7 address bits, 16 data bits
   localparam int FRAME_BITS = 24;
   localparam int HDR_BITS = 8;
   localparam logic [4:0] HDR_LAST = 5'h07;
   localparam logic [4:0] FRAME_LAST = 5'h17;

   // Field positions
   localparam int THERM_MSB = 8;
   localparam int BURST_LSB = 10;
   localparam int BURST_MSB = 13;
   localparam int SLEEP_LSB = 10;
   localparam int SLEEP_MSB = 15;
   localparam int TRIM_LSB = 7;
   localparam int TRIM_MSB = 15;
   localparam int BIAS_BIT = 6;
   localparam int SYNC_BIT = 5;
   localparam int TRIG_BIT = 4;

   // Values after reset and fixed values
   localparam logic [15:0] SOFT_RESET_KEY = 16'hd2f0;
   localparam logic [4:0] BURST_BASE = 5'h0a;
   localparam logic [5:0] SLEEP_RST = 6'h00;
   localparam logic [8:0] TRIM_RST = 9'h1ff;
   localparam logic BIAS_RST = 1'b1;
   localparam logic SYNC_RST = 1'b1;
   localparam logic TRIG_RST = 1'b1;
   localparam logic [3:0] FIXED_ONES = 4'hf;

   // Sleep selection codes
   localparam logic [5:0] SLEEP_FULL = 6'h00;
   localparam logic [5:0] SLEEP_STANDBY = 6'h20;
   localparam logic [5:0] SLEEP_DEEP = 6'h30;
   localparam logic [5:0] SLEEP_LIGHT = 6'h35;

   // Wake-up times and their cycle counts at 50 MHz
   localparam int CLK_PERIOD_NS = 20;
   localparam int WAKE_FULL_NS = 2500000;
   localparam int WAKE_STANDBY_NS = 100000;
   localparam int WAKE_DEEP_NS = 20000;
   localparam int WAKE_LIGHT_NS = 2000;
   localparam int WAKE_FULL_CYC = (WAKE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_STANDBY_CYC = (WAKE_STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_DEEP_CYC = (WAKE_DEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_LIGHT_CYC = (WAKE_LIGHT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_W = 17;

   typedef enum logic [1:0] {ACR_LP_FULL, ACR_LP_STANDBY, ACR_LP_DEEP, ACR_LP_LIGHT} acr_lp_mode_t;
   typedef enum logic [1:0] {ACR_PWR_ACTIVE, ACR_PWR_SLEEP, ACR_PWR_WAKE} acr_power_state_t;

   // One decoded serial access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [15:0] wdata;
   } acr_spi_req_t;

endpackage : acr_pkg

// >>> rtl/acr_reg_bank.sv
// Converter configuration register bank: thermal, soft reset, burst, sleep, bias and buffers
`timescale 1ns/10ps
// Operation
// - Temperature reading appears read-only in bits 8..0 of register 2B.
// - Writing key d2f0 to register 2C returns all registers to defaults.
// - The reset register clears itself after the software reset.
// - Burst count field 13..10 of 34 gives 10 plus code samples.
// - Low-power state is entered only while the enable pin is low.
// - Sleep codes select shutdown, standby, deep or light sleep with wake times.
// - Bit 6 of 38 powers the fuse bias, default one.
// - Bit 5 of 38 enables the sync input buffer, default one.
// - Bit 4 of 38 enables the trigger input buffer, default one.
module acr_reg_bank #(
   parameter int WAKE_FULL_CYC = acr_pkg::WAKE_FULL_CYC,
   parameter int WAKE_STANDBY_CYC = acr_pkg::WAKE_STANDBY_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial configuration port
   input wire logic sen_n_pin,
   input wire logic sclk_pin,
   input wire logic sdin_pin,
   output logic sdout,
   // Device pins and sensor
   input wire logic enable_pin,
   input wire logic [8:0] thermal_code,
   // Configuration outputs
   output logic [4:0] burst_len,
   output acr_pkg::acr_lp_mode_t lp_mode,
   output acr_pkg::acr_power_state_t power_state,
   output logic device_awake,
   output logic [8:0] performance_trim_bits,
   output logic fuse_bias_on,
   output logic sync_buffer_on,
   output logic capture_start_buffer_on
);

   acr_pkg::acr_spi_req_t req;
   logic [15:0] rdata;
   logic [8:0] therm_s1, therm_s2, therm_s3, therm_val, next_therm_val;
   logic en_s1, en_s2;
   logic [5:0] sleep_code, next_sleep_code;
   logic [4:0] next_burst_len;
   logic [8:0] next_trim;
   logic next_bias, next_sync, next_trig;
   logic soft_pend, next_soft_pend;
   acr_pkg::acr_power_state_t next_power_state;
   acr_pkg::acr_lp_mode_t next_lp_mode;
   logic next_awake;
   logic [acr_pkg::WAKE_W-1:0] wake_cnt, next_wake_cnt;

   // Unknown codes fall back to full shutdown, the safest state
   function automatic acr_pkg::acr_lp_mode_t lp_decode(input logic [5:0] code);
      case (code)
         acr_pkg::SLEEP_STANDBY: lp_decode = acr_pkg::ACR_LP_STANDBY;
         acr_pkg::SLEEP_DEEP: lp_decode = acr_pkg::ACR_LP_DEEP;
         acr_pkg::SLEEP_LIGHT: lp_decode = acr_pkg::ACR_LP_LIGHT;
         default: lp_decode = acr_pkg::ACR_LP_FULL;
      endcase
   endfunction : lp_decode

   // Wake counter load value, one less than the wake time in cycles
   function automatic logic [acr_pkg::WAKE_W-1:0] wake_load(input acr_pkg::acr_lp_mode_t m);
      case (m)
         acr_pkg::ACR_LP_STANDBY: wake_load = acr_pkg::WAKE_W'(WAKE_STANDBY_CYC - 1);
         acr_pkg::ACR_LP_DEEP: wake_load = acr_pkg::WAKE_W'(acr_pkg::WAKE_DEEP_CYC - 1);
         acr_pkg::ACR_LP_LIGHT: wake_load = acr_pkg::WAKE_W'(acr_pkg::WAKE_LIGHT_CYC - 1);
         default: wake_load = acr_pkg::WAKE_W'(WAKE_FULL_CYC - 1);
      endcase
   endfunction : wake_load

   acr_spi_frame u_spi (
      .clk(clk),
      .rst(rst),
      .sen_n_pin(sen_n_pin),
      .sclk_pin(sclk_pin),
      .sdin_pin(sdin_pin),
      .sdout(sdout),
      .rdata(rdata),
      .req(req)
   );

   // Sensor code and enable pin arrive from outside the clock domain
   always_ff @(posedge clk) begin
      therm_s1 <= thermal_code;
      therm_s2 <= therm_s1;
      therm_s3 <= therm_s2;
      therm_val <= next_therm_val;
      en_s1 <= enable_pin;
      en_s2 <= en_s1;
   end

   // Sensor bits may resync on different edges; the word is taken only once two samples agree
   always_comb begin
      next_therm_val = therm_val;
      if (therm_s2 == therm_s3) begin
         next_therm_val = therm_s2;
      end
   end

   // Read-back mux; fixed-zero bits read as zero
   always_comb begin
      rdata = 16'h0000;
      case (req.addr)
         acr_pkg::ADDR_THERMAL: rdata[acr_pkg::THERM_MSB:0] = therm_val;
         acr_pkg::ADDR_SOFT_RESET: rdata = 16'h0000;
         acr_pkg::ADDR_BURST: rdata[acr_pkg::BURST_MSB:acr_pkg::BURST_LSB] = 4'(burst_len - acr_pkg::BURST_BASE);
         acr_pkg::ADDR_SLEEP: rdata[acr_pkg::SLEEP_MSB:acr_pkg::SLEEP_LSB] = sleep_code;
         acr_pkg::ADDR_BIAS: begin
            rdata[acr_pkg::TRIM_MSB:acr_pkg::TRIM_LSB] = performance_trim_bits;
            rdata[acr_pkg::BIAS_BIT] = fuse_bias_on;
            rdata[acr_pkg::SYNC_BIT] = sync_buffer_on;
            rdata[acr_pkg::TRIG_BIT] = capture_start_buffer_on;
            rdata[3:0] = acr_pkg::FIXED_ONES;
         end
         default: rdata = 16'h0000;
      endcase
   end

   // Register writes and software reset; the thermal register ignores writes
   always_comb begin
      next_burst_len = burst_len;
      next_sleep_code = sleep_code;
      next_trim = performance_trim_bits;
      next_bias = fuse_bias_on;
      next_sync = sync_buffer_on;
      next_trig = capture_start_buffer_on;
      next_soft_pend = 1'b0;
      if (soft_pend) begin
         next_burst_len = acr_pkg::BURST_BASE;
         next_sleep_code = acr_pkg::SLEEP_RST;
         next_trim = acr_pkg::TRIM_RST;
         next_bias = acr_pkg::BIAS_RST;
         next_sync = acr_pkg::SYNC_RST;
         next_trig = acr_pkg::TRIG_RST;
      end else if (req.wr) begin
         case (req.addr)
            acr_pkg::ADDR_SOFT_RESET: next_soft_pend = (req.wdata == acr_pkg::SOFT_RESET_KEY);
            acr_pkg::ADDR_BURST: next_burst_len = acr_pkg::BURST_BASE +
               {1'b0, req.wdata[acr_pkg::BURST_MSB:acr_pkg::BURST_LSB]};
            acr_pkg::ADDR_SLEEP: next_sleep_code = req.wdata[acr_pkg::SLEEP_MSB:acr_pkg::SLEEP_LSB];
            acr_pkg::ADDR_BIAS: begin
               next_trim = req.wdata[acr_pkg::TRIM_MSB:acr_pkg::TRIM_LSB];
               next_bias = req.wdata[acr_pkg::BIAS_BIT];
               next_sync = req.wdata[acr_pkg::SYNC_BIT];
               next_trig = req.wdata[acr_pkg::TRIG_BIT];
            end
            default: next_soft_pend = 1'b0;
         endcase
      end
   end

   // Power sequencing: mode is latched on entry so a later write cannot shorten the wake
   always_comb begin
      next_power_state = power_state;
      next_lp_mode = lp_mode;
      next_wake_cnt = wake_cnt;
      case (power_state)
         acr_pkg::ACR_PWR_ACTIVE: begin
            if (!en_s2) begin
               next_power_state = acr_pkg::ACR_PWR_SLEEP;
               next_lp_mode = lp_decode(sleep_code);
            end
         end
         acr_pkg::ACR_PWR_SLEEP: begin
            if (en_s2) begin
               next_power_state = acr_pkg::ACR_PWR_WAKE;
               next_wake_cnt = wake_load(lp_mode);
            end
         end
         acr_pkg::ACR_PWR_WAKE: begin
            if (!en_s2) begin
               next_power_state = acr_pkg::ACR_PWR_SLEEP;
            end else if (wake_cnt == '0) begin
               next_power_state = acr_pkg::ACR_PWR_ACTIVE;
            end else begin
               next_wake_cnt = wake_cnt - 1'b1;
            end
         end
         default: next_power_state = acr_pkg::ACR_PWR_ACTIVE;
      endcase
      next_awake = (next_power_state == acr_pkg::ACR_PWR_ACTIVE);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         burst_len <= acr_pkg::BURST_BASE;
         sleep_code <= acr_pkg::SLEEP_RST;
         performance_trim_bits <= acr_pkg::TRIM_RST;
         fuse_bias_on <= acr_pkg::BIAS_RST;
         sync_buffer_on <= acr_pkg::SYNC_RST;
         capture_start_buffer_on <= acr_pkg::TRIG_RST;
         soft_pend <= 1'b0;
         power_state <= acr_pkg::ACR_PWR_ACTIVE;
         lp_mode <= acr_pkg::ACR_LP_FULL;
         wake_cnt <= '0;
         device_awake <= 1'b1;
      end else begin
         burst_len <= next_burst_len;
         sleep_code <= next_sleep_code;
         performance_trim_bits <= next_trim;
         fuse_bias_on <= next_bias;
         sync_buffer_on <= next_sync;
         capture_start_buffer_on <= next_trig;
         soft_pend <= next_soft_pend;
         power_state <= next_power_state;
         lp_mode <= next_lp_mode;
         wake_cnt <= next_wake_cnt;
         device_awake <= next_awake;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_key_write;
      req.wr && req.addr == acr_pkg::ADDR_SOFT_RESET && req.wdata == acr_pkg::SOFT_RESET_KEY && !soft_pend;
   endsequence
   sequence s_defaults;
      burst_len == 5'h0a && fuse_bias_on && sync_buffer_on && capture_start_buffer_on &&
         performance_trim_bits == 9'h1ff && sleep_code == 6'h00;
   endsequence

   property p_thermal;
      req.addr == acr_pkg::ADDR_THERMAL |-> rdata == {7'h00, therm_val};
   endproperty
   a_thermal: assert property (p_thermal) else $error("thermal read mismatch");
   property p_soft_reset;
      s_key_write |=> soft_pend ##1 s_defaults;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore defaults");
   property p_self_clear;
      soft_pend |=> !soft_pend;
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("reset register did not self clear");
   property p_burst;
      req.wr && req.addr == acr_pkg::ADDR_BURST && !soft_pend |=> burst_len == 5'($past(req.wdata[13:10]) + 5'h0a);
   endproperty
   a_burst: assert property (p_burst) else $error("burst count wrong");
   property p_sleep_entry;
      power_state == acr_pkg::ACR_PWR_ACTIVE && !en_s2 |=> power_state == acr_pkg::ACR_PWR_SLEEP && !device_awake;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
   property p_awake_only_enabled;
      power_state == acr_pkg::ACR_PWR_ACTIVE && en_s2 |=> power_state == acr_pkg::ACR_PWR_ACTIVE && device_awake;
   endproperty
   a_awake_only_enabled: assert property (p_awake_only_enabled) else $error("left active while enabled");
   property p_light_wake;
      power_state == acr_pkg::ACR_PWR_SLEEP && en_s2 && lp_mode == acr_pkg::ACR_LP_LIGHT ##1 en_s2 [*8]
         |-> power_state == acr_pkg::ACR_PWR_WAKE && wake_cnt == acr_pkg::WAKE_W'(acr_pkg::WAKE_LIGHT_CYC - 8);
   endproperty
   a_light_wake: assert property (p_light_wake) else $error("light sleep wake count wrong");
   property p_bias_bits;
      req.wr && req.addr == acr_pkg::ADDR_BIAS && !soft_pend |=> fuse_bias_on == $past(req.wdata[6]) &&
         sync_buffer_on == $past(req.wdata[5]) && capture_start_buffer_on == $past(req.wdata[4]);
   endproperty
   a_bias_bits: assert property (p_bias_bits) else $error("bias or buffer enable wrong");
   property p_fixed_ones;
      req.addr == acr_pkg::ADDR_BIAS |-> rdata[3:0] == 4'hf;
   endproperty
   a_fixed_ones: assert property (p_fixed_ones) else $error("fixed ones not read back");

endmodule : acr_reg_bank

// >>> rtl/acr_spi_frame.sv
// Serial port frame receiver and read-data shifter, oversampled on clk
`timescale 1ns/10ps
module acr_spi_frame (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial pins
   input wire logic sen_n_pin,
   input wire logic sclk_pin,
   input wire logic sdin_pin,
   output logic sdout,
   // Register side
   input wire logic [15:0] rdata,
   output acr_pkg::acr_spi_req_t req
);

   logic sen_n_s1, sen_n_s2, sclk_s1, sclk_s2, sclk_d, sdin_s1, sdin_s2;
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [23:0] shreg, next_shreg;
   logic [15:0] out_sh, next_out_sh;
   logic next_sdout;
   acr_pkg::acr_spi_req_t next_req;

   // Pins cross into clk domain through two flops
   always_ff @(posedge clk) begin
      sen_n_s1 <= sen_n_pin;
      sen_n_s2 <= sen_n_s1;
      sclk_s1 <= sclk_pin;
      sclk_s2 <= sclk_s1;
      sdin_s1 <= sdin_pin;
      sdin_s2 <= sdin_s1;
      sclk_d <= sclk_s2;
   end

   // Shift on rising sclk, drive read data on falling sclk
   always_comb begin
      logic [23:0] word;
      word = {shreg[22:0], sdin_s2};
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_out_sh = out_sh;
      next_sdout = sdout;
      next_req = req;
      next_req.wr = 1'b0;
      next_req.rd = 1'b0;
      if (req.rd) begin
         next_out_sh = rdata; // Loaded one cycle after the header, before the next falling edge
      end
      if (sen_n_s2) begin
         next_bit_cnt = 5'h00; // Deselect aborts a partial frame
         next_sdout = 1'b0;
      end else if (sclk_s2 && !sclk_d) begin
         next_shreg = word;
         next_bit_cnt = bit_cnt + 5'h01;
         if (bit_cnt == acr_pkg::HDR_LAST) begin
            next_req.addr = word[6:0];
            next_req.rd = word[7];
         end
         if (bit_cnt == acr_pkg::FRAME_LAST) begin
            next_req.wr = !word[23];
            next_req.wdata = word[15:0];
            next_bit_cnt = 5'h00;
         end
      end else if (!sclk_s2 && sclk_d && bit_cnt >= 5'h08) begin
         next_sdout = out_sh[15];
         next_out_sh = {out_sh[14:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bit_cnt <= 5'h00;
         shreg <= 24'h000000;
         out_sh <= 16'h0000;
         sdout <= 1'b0;
         req <= '0;
      end else begin
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         out_sh <= next_out_sh;
         sdout <= next_sdout;
         req <= next_req;
      end
   end

endmodule : acr_spi_frame

// >>> tb/acr_spi_host.sv
// Serial configuration host model that drives the bank's serial port
`timescale 1ns/10ps
module acr_spi_host (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic sen_n_pin,
   output logic sclk_pin,
   output logic sdin_pin,
   input wire logic sdout
);
   // Each sclk phase spans 10 clk, above the 3-cycle minimum
   localparam int HALF = 10;

   // Idle levels at time zero
   initial begin
      sen_n_pin = 1'b1;
      sclk_pin = 1'b0;
      sdin_pin = 1'b0;
   end

   // One whole 24-bit frame, MSB first; every pin changes only just after a clk fall
   task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wdata,
                       output logic [15:0] rdata);
      logic [23:0] frame;
      frame = {rd, addr, wdata}; // Callers keep fixed zeros at zero and trim bits at one
      rdata = 16'h0000;
      @(negedge clk);
      sen_n_pin = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdin_pin = frame[i];
         sclk_pin = 1'b0;
         repeat (HALF) @(negedge clk);
         // Late in the low phase, so sdout has long settled
         if (i < 16) rdata[i] = sdout;
         sclk_pin = 1'b1;
         repeat (HALF) @(negedge clk);
      end
      sclk_pin = 1'b0;
      sen_n_pin = 1'b1;
      sdin_pin = ~sdin_pin; // Released line must not keep showing the last bit
      repeat (HALF) @(negedge clk);
   endtask : xfer
endmodule : acr_spi_host

// >>> tb/testbench.sv
// Self-checking bench for the converter configuration register bank
`timescale 1ns/10ps
module testbench;
   // Shortened wake counts for the two long modes
   localparam int FULL_CYC = 40;
   localparam int STBY_CYC = 20;
   localparam int LIMIT = 60000;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic enable_pin = 1'b1;
   logic [8:0] thermal_code = 9'h000;
   logic sen_n_pin, sclk_pin, sdin_pin, sdout;
   logic [4:0] burst_len;
   acr_pkg::acr_lp_mode_t lp_mode;
   acr_pkg::acr_power_state_t power_state;
   logic device_awake, fuse_bias_on, sync_buffer_on, capture_start_buffer_on;
   logic [8:0] performance_trim_bits;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   always #10 clk = ~clk;

   acr_reg_bank #(.WAKE_FULL_CYC(FULL_CYC), .WAKE_STANDBY_CYC(STBY_CYC)) i_dut (
      .clk(clk), .rst(rst), .sen_n_pin(sen_n_pin), .sclk_pin(sclk_pin), .sdin_pin(sdin_pin),
      .sdout(sdout), .enable_pin(enable_pin), .thermal_code(thermal_code), .burst_len(burst_len),
      .lp_mode(lp_mode), .power_state(power_state), .device_awake(device_awake),
      .performance_trim_bits(performance_trim_bits), .fuse_bias_on(fuse_bias_on),
      .sync_buffer_on(sync_buffer_on), .capture_start_buffer_on(capture_start_buffer_on)
   );

   acr_spi_host i_host (
      .clk(clk), .sen_n_pin(sen_n_pin), .sclk_pin(sclk_pin), .sdin_pin(sdin_pin), .sdout(sdout)
   );

   // Verdict and end of run, shared by the main sequence and the watchdog
   task automatic complete_run();
      if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [6:0] addr, input logic [15:0] data);
      logic [15:0] unused;
      i_host.xfer(1'b0, addr, data, unused);
   endtask : wr

   task automatic rd_check(input string what, input logic [6:0] addr, input logic [15:0] exp);
      logic [15:0] got;
      i_host.xfer(1'b1, addr, 16'h0000, got);
      check(what, got, exp);
   endtask : rd_check

   // Expected image of the bias and buffer register, low nibble always ones
   function automatic logic [15:0] bias_img(input logic b, input logic s, input logic t);
      return {acr_pkg::TRIM_RST, b, s, t, acr_pkg::FIXED_ONES};
   endfunction : bias_img

   // Outputs and read-back after reset
   task automatic t_defaults();
      check("burst_len", {11'h000, burst_len}, 16'h000a);
      check("trim", {7'h00, performance_trim_bits}, 16'h01ff);
      check("bias", {15'h0000, fuse_bias_on}, 16'h0001);
      check("sync", {15'h0000, sync_buffer_on}, 16'h0001);
      check("trig", {15'h0000, capture_start_buffer_on}, 16'h0001);
      rd_check("rd 38", acr_pkg::ADDR_BIAS, bias_img(1'b1, 1'b1, 1'b1));
      rd_check("rd 34", acr_pkg::ADDR_BURST, 16'h0000);
      rd_check("rd 37", acr_pkg::ADDR_SLEEP, 16'h0000);
   endtask : t_defaults

   // Sensor value shows in the low nine bits and ignores writes
   task automatic t_thermal();
      thermal_code = 9'h1a5;
      rd_check("thermal", acr_pkg::ADDR_THERMAL, 16'h01a5);
      wr(acr_pkg::ADDR_THERMAL, 16'h005a); // Fixed-zero bits written as zero
      rd_check("thermal ro", acr_pkg::ADDR_THERMAL, 16'h01a5);
   endtask : t_thermal

   // Boundary codes of the burst field
   task automatic t_burst();
      logic [3:0] codes[3] = '{4'h0, 4'h1, 4'hf};
      foreach (codes[k]) begin
         wr(acr_pkg::ADDR_BURST, {2'b00, codes[k], 10'h000});
         check("burst_len", {11'h000, burst_len}, 16'h000a + codes[k]);
         rd_check("rd 34", acr_pkg::ADDR_BURST, {2'b00, codes[k], 10'h000});
      end
   endtask : t_burst

   // Enable-bit patterns 101, 010 and 111, with zeros written to the fixed-ones nibble
   task automatic t_bias();
      logic [2:0] pats[3] = '{3'b101, 3'b010, 3'b111};
      foreach (pats[k]) begin
         wr(acr_pkg::ADDR_BIAS, {9'h1ff, pats[k], 4'h0});
         check("bias", {15'h0000, fuse_bias_on}, {15'h0000, pats[k][2]});
         check("sync", {15'h0000, sync_buffer_on}, {15'h0000, pats[k][1]});
         check("trig", {15'h0000, capture_start_buffer_on}, {15'h0000, pats[k][0]});
         rd_check("rd 38", acr_pkg::ADDR_BIAS, bias_img(pats[k][2], pats[k][1], pats[k][0]));
      end
   endtask : t_bias

   // Wrong key leaves settings alone, right key restores defaults and self-clears
   task automatic t_soft_reset();
      wr(acr_pkg::ADDR_BURST, {2'b00, 4'h5, 10'h000});
      wr(acr_pkg::ADDR_SLEEP, {acr_pkg::SLEEP_LIGHT, 10'h000});
      wr(acr_pkg::ADDR_BIAS, {9'h1ff, 3'b000, 4'h0});
      wr(acr_pkg::ADDR_SOFT_RESET, 16'hd2f1);
      check("burst kept", {11'h000, burst_len}, 16'h000f);
      check("bias kept", {15'h0000, fuse_bias_on}, 16'h0000);
      wr(acr_pkg::ADDR_SOFT_RESET, 16'hd2f0);
      check("burst_len", {11'h000, burst_len}, 16'h000a);
      check("buffers", {13'h0000, fuse_bias_on, sync_buffer_on, capture_start_buffer_on}, 16'h0007);
      rd_check("rd 37", acr_pkg::ADDR_SLEEP, 16'h0000);
      rd_check("rd 2c", acr_pkg::ADDR_SOFT_RESET, 16'h0000);
   endtask : t_soft_reset

   // Every sleep code: entered only with enable low, then wake time measured
   task automatic t_sleep();
      // Last entry is an unlisted code, which must fall back to full shutdown
      logic [5:0] codes[5] = '{acr_pkg::SLEEP_FULL, acr_pkg::SLEEP_STANDBY, acr_pkg::SLEEP_DEEP,
                               acr_pkg::SLEEP_LIGHT, 6'h11};
      int wake[5] = '{FULL_CYC, STBY_CYC, acr_pkg::WAKE_DEEP_CYC, acr_pkg::WAKE_LIGHT_CYC, FULL_CYC};
      int n;
      foreach (codes[k]) begin
         wr(acr_pkg::ADDR_SLEEP, {codes[k], 10'h000});
         check("awake while enabled", {14'h0000, power_state}, {14'h0000, acr_pkg::ACR_PWR_ACTIVE});
         enable_pin = 1'b0;
         repeat (8) @(negedge clk);
         check("asleep", {14'h0000, power_state}, {14'h0000, acr_pkg::ACR_PWR_SLEEP});
         check("lp_mode", {14'h0000, lp_mode}, 16'(k % 4));
         check("awake low", {15'h0000, device_awake}, 16'h0000);
         enable_pin = 1'b1;
         n = 0;
         // Sync delay adds a few cycles on top of the wake count
         while (device_awake !== 1'b1 && n < 1200) begin
            @(negedge clk);
            n++;
         end
         check("wake time", {15'h0000, (n > wake[k]) && (n <= wake[k] + 6)}, 16'h0001);
      end
   endtask : t_sleep

   // Watchdog over the whole run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_errors++;
         complete_run();
      end
   end

   // Main sequence
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_defaults();
      t_thermal();
      t_burst();
      t_bias();
      t_soft_reset();
      t_sleep();
      complete_run();
   end
endmodule : testbench
